// file: dbw_bridge.sv
module dbw_bridge import dbw_pkg::*; (
	input wire logic ref_clk_i,
	input wire logic srst_i,
	input wire logic io_out_i,
	input wire logic io_in_i,
	input wire logic [5:0] io_addr_i,
	input wire logic [0:35] io_data_i,
	output logic [0:35] io_rdata_o,
	output logic access_collision_o,
	output logic busy_o,
	output logic done_o,
	output logic feeder_start_request_o,
	output logic controller_word_pulse_o,
	output logic [11:0] first_control_word_pointer_o,
	input wire dbw_pins_t pins_i,
	output dbw_ctl_t drv_ctl_o,
	output logic cycle_strobe_o,
	output logic ctl_data_oe_o,
	output logic run_o,
	output logic write_echo_o,
	output logic [17:0] wdata_o,
	output logic wdata_oe_o
);

	function automatic logic [15:0] word_data(input logic [0:35] w);
		return w[DATA_LO:DATA_HI];
	endfunction

	function automatic logic is_acc_addr(input logic [5:0] a);
		return a < XFER_CMD_ADDR;
	endfunction

	// ---------------------------------------------
	// pin synchronisers and edge detection
	// ---------------------------------------------
	dbw_pins_t pins_m_r;
	dbw_pins_t pins_s_r;
	logic busy_d_r;
	logic wpulse_d_r;
	logic ack_d_r;
	logic sclk_d_r;
	logic blk_end_d_r;

	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			pins_m_r <= '0;
			pins_s_r <= '0;
		end else begin
			pins_m_r <= pins_i;
			pins_s_r <= pins_m_r;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			busy_d_r <= 1'b0;
			wpulse_d_r <= 1'b0;
			ack_d_r <= 1'b0;
			sclk_d_r <= 1'b0;
			blk_end_d_r <= 1'b0;
		end else begin
			busy_d_r <= pins_s_r.busy;
			wpulse_d_r <= pins_s_r.wpulse;
			ack_d_r <= pins_s_r.ack;
			sclk_d_r <= pins_s_r.sclk;
			blk_end_d_r <= pins_s_r.blk_end;
		end
	end

	logic busy_rise;
	logic busy_fall;
	logic wpulse_rise;
	logic ack_rise;
	logic sclk_rise;
	logic blk_end_rise;
	assign busy_rise = pins_s_r.busy & ~busy_d_r;
	assign busy_fall = ~pins_s_r.busy & busy_d_r;
	assign wpulse_rise = pins_s_r.wpulse & ~wpulse_d_r;
	assign ack_rise = pins_s_r.ack & ~ack_d_r;
	assign sclk_rise = pins_s_r.sclk & ~sclk_d_r;
	assign blk_end_rise = pins_s_r.blk_end & ~blk_end_d_r;

	// ---------------------------------------------
	// register access sequencer
	// ---------------------------------------------
	dbw_acc_state_t acc_state_r;
	logic [5:0] cnt_r;
	logic acc_rd_r;
	logic ctl_cyc_r;
	logic ctl_req_r;
	logic [0:35] pend_r;
	logic cyc_in_flight_r;
	logic acc_req;
	logic acc_accept;
	logic ctl_start;
	logic addr_load;
	logic read_data_load;
	logic cycle_end;
	logic ack_tmo;
	logic blocked_fn;
	logic cnt_zero;
	logic [15:0] pend_data;

	assign cnt_zero = cnt_r == 6'h00;
	assign pend_data = word_data(pend_r);
	assign acc_req = io_out_i && is_acc_addr(io_addr_i);
	assign acc_accept = acc_req && acc_state_r == AC_IDLE;
	assign ctl_start = ctl_req_r && acc_state_r == AC_IDLE && !acc_accept;
	assign addr_load = acc_state_r == AC_ADDR_DLY && cnt_zero;
	assign read_data_load = acc_state_r == AC_RD_DESKEW && cnt_zero;
	assign ack_tmo = acc_state_r == AC_WAIT_ACK && cnt_zero && !ack_rise;
	assign cycle_end = (acc_state_r == AC_WAIT_ACK && ((ack_rise && !acc_rd_r) || ack_tmo))
		|| (acc_state_r == AC_PARITY && cnt_zero);
	assign blocked_fn = pend_r[CTOD_BIT] && pend_r[REG_SEL_LO:REG_SEL_HI] == CTL_REG_SEL
		&& pend_data[FN_XFER_BIT];

	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			pend_r <= WORD_RST;
		end else if (acc_accept) begin
			pend_r <= io_data_i;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			acc_state_r <= AC_IDLE;
			cnt_r <= 6'h00;
			acc_rd_r <= 1'b0;
			ctl_cyc_r <= 1'b0;
		end else begin
			case (acc_state_r)
				AC_IDLE: begin
					if (acc_accept) begin
						acc_state_r <= AC_ADDR_DLY;
						cnt_r <= 6'(ADDR_DLY_CYC - 1);
						ctl_cyc_r <= 1'b0;
					end else if (ctl_start) begin
						acc_state_r <= AC_SETTLE;
						cnt_r <= 6'(SETTLE_CYC - 1);
						ctl_cyc_r <= 1'b1;
						acc_rd_r <= 1'b0;
					end
				end
				AC_ADDR_DLY: begin
					if (cnt_zero) begin
						acc_state_r <= AC_SETTLE;
						cnt_r <= 6'(SETTLE_CYC - 1);
						acc_rd_r <= ~pend_r[CTOD_BIT];
					end else begin
						cnt_r <= cnt_r - 6'h01;
					end
				end
				AC_SETTLE: begin
					if (cnt_zero) begin
						acc_state_r <= AC_WAIT_ACK;
						cnt_r <= 6'(ACK_TMO_CYC - 1);
					end else begin
						cnt_r <= cnt_r - 6'h01;
					end
				end
				AC_WAIT_ACK: begin
					if (ack_rise && acc_rd_r) begin
						acc_state_r <= AC_RD_DESKEW;
						cnt_r <= 6'(RD_DESKEW_CYC - 1);
					end else if (ack_rise || cnt_zero) begin
						acc_state_r <= AC_IDLE;
					end else begin
						cnt_r <= cnt_r - 6'h01;
					end
				end
				AC_RD_DESKEW: begin
					if (cnt_zero) begin
						acc_state_r <= AC_PARITY;
						cnt_r <= 6'(PAR_WIN_CYC - 1);
					end else begin
						cnt_r <= cnt_r - 6'h01;
					end
				end
				AC_PARITY: begin
					if (cnt_zero) begin
						acc_state_r <= AC_IDLE;
					end else begin
						cnt_r <= cnt_r - 6'h01;
					end
				end
				default: begin
					acc_state_r <= AC_IDLE;
				end
			endcase
		end
	end

	// cycle flags and drive control bus
	logic strobe_r;
	dbw_ctl_t ctl_r;
	logic [0:35] xcmd_r;

	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			cyc_in_flight_r <= 1'b0;
			strobe_r <= 1'b0;
		end else begin
			if (addr_load || ctl_start) begin
				cyc_in_flight_r <= 1'b1;
			end else if (cycle_end) begin
				cyc_in_flight_r <= 1'b0;
			end
			if (acc_state_r == AC_SETTLE && cnt_zero) begin
				strobe_r <= 1'b1;
			end else if (cycle_end) begin
				strobe_r <= 1'b0;
			end
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			ctl_r <= '0;
		end else if (addr_load) begin
			ctl_r.sel <= pend_r[REG_SEL_LO:REG_SEL_HI];
			ctl_r.ctod <= pend_r[CTOD_BIT];
			ctl_r.drv <= pend_r[DRSEL_LO:DRSEL_HI];
			ctl_r.data <= word_data(pend_r);
			if (blocked_fn) begin
				ctl_r.data[GO_BIT] <= 1'b0;
			end
		end else if (ctl_start) begin
			ctl_r.sel <= CTL_REG_SEL;
			ctl_r.ctod <= 1'b1;
			ctl_r.drv <= xcmd_r[DRSEL_LO:DRSEL_HI];
			ctl_r.data <= {10'h000, xcmd_r[FN_LO:FN_HI]};
		end
	end

	// ---------------------------------------------
	// access buffer and status flags
	// ---------------------------------------------
	logic [0:35] dab_r;
	logic [0:35] dab_view;
	logic collision_r;
	logic noresp_r;
	logic parf_r;
	logic stale_r;
	logic block_r;

	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			dab_r <= WORD_RST;
		end else if (addr_load) begin
			dab_r[REG_SEL_LO:CTOD_BIT] <= pend_r[REG_SEL_LO:CTOD_BIT];
			dab_r[DRSEL_LO:DRSEL_HI] <= pend_r[DRSEL_LO:DRSEL_HI];
			dab_r[DATA_LO:DATA_HI] <= pend_r[DATA_LO:DATA_HI];
		end else if (read_data_load) begin
			dab_r[DATA_LO:DATA_HI] <= pins_s_r.ddata;
			dab_r[PAR_LINE_BIT] <= pins_s_r.par;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			collision_r <= 1'b0;
			noresp_r <= 1'b0;
			parf_r <= 1'b0;
			stale_r <= 1'b0;
			block_r <= 1'b0;
		end else begin
			if (acc_req && acc_state_r != AC_IDLE) begin
				collision_r <= 1'b1;
			end else if (acc_accept) begin
				collision_r <= 1'b0;
			end
			if (ack_tmo) begin
				noresp_r <= 1'b1;
			end else if (acc_accept) begin
				noresp_r <= 1'b0;
			end
			if (acc_state_r == AC_PARITY && cnt_zero
				&& !(^{dab_r[DATA_LO:DATA_HI], dab_r[PAR_LINE_BIT]})) begin
				parf_r <= 1'b1;
			end else if (acc_accept) begin
				parf_r <= 1'b0;
			end
			if (io_in_i && is_acc_addr(io_addr_i) && acc_state_r != AC_IDLE) begin
				stale_r <= 1'b1;
			end else if (acc_accept) begin
				stale_r <= 1'b0;
			end
			if (addr_load && blocked_fn) begin
				block_r <= 1'b1;
			end else if (acc_accept) begin
				block_r <= 1'b0;
			end
		end
	end

	always_comb begin
		dab_view = dab_r;
		dab_view[NORESP_BIT] = noresp_r;
		dab_view[PARF_BIT] = parf_r;
		dab_view[STALE_BIT] = stale_r;
		dab_view[BLOCK_BIT] = block_r;
	end

	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			io_rdata_o <= WORD_RST;
		end else if (io_in_i) begin
			io_rdata_o <= (io_addr_i == XFER_CMD_ADDR) ? xcmd_r : dab_view;
		end
	end

	// ---------------------------------------------
	// transfer session control
	// ---------------------------------------------
	logic busy_r;
	logic done_r;
	logic pending_r;
	logic session_r;
	logic owned_r;
	logic first_seen_r;
	logic run_r;
	logic cwp_r;
	logic xcmd_load;
	logic fbuf_to_asm;
	logic xfer_cmd;

	assign xfer_cmd = io_out_i && io_addr_i == XFER_CMD_ADDR;
	assign xcmd_load = xfer_cmd && !busy_r;

	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			xcmd_r <= WORD_RST;
		end else if (xcmd_load) begin
			xcmd_r <= io_data_i;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			busy_r <= 1'b0;
			done_r <= 1'b0;
		end else if (blk_end_rise && busy_r) begin
			busy_r <= 1'b0;
			done_r <= 1'b1;
		end else if (xcmd_load) begin
			busy_r <= 1'b1;
			done_r <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			pending_r <= 1'b0;
			session_r <= 1'b0;
			owned_r <= 1'b0;
		end else begin
			pending_r <= xcmd_load;
			if (pending_r) begin
				session_r <= 1'b1;
			end else if (busy_fall) begin
				session_r <= 1'b0;
			end
			if (busy_rise && session_r) begin
				owned_r <= 1'b1;
			end else if (busy_fall) begin
				owned_r <= 1'b0;
			end
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			cwp_r <= 1'b0;
		end else begin
			cwp_r <= (busy_rise && session_r) || fbuf_to_asm;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			first_seen_r <= 1'b0;
			ctl_req_r <= 1'b0;
		end else begin
			if (wpulse_rise && owned_r && !first_seen_r) begin
				first_seen_r <= 1'b1;
				ctl_req_r <= 1'b1;
			end else begin
				if (xcmd_load) begin
					first_seen_r <= 1'b0;
				end
				if (ctl_start) begin
					ctl_req_r <= 1'b0;
				end
			end
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			run_r <= 1'b0;
		end else if (acc_state_r == AC_WAIT_ACK && ack_rise && ctl_cyc_r) begin
			run_r <= 1'b1;
		end else if (blk_end_rise || xcmd_load) begin
			run_r <= 1'b0;
		end
	end

	// ---------------------------------------------
	// write data path
	// ---------------------------------------------
	logic [0:35] fbuf_r;
	logic fbuf_full_r;
	logic [0:35] asm_r;
	logic asm_full_r;
	logic asm_half_r;
	logic [17:0] fifo_mem_r [2];
	logic fifo_wp_r;
	logic fifo_rp_r;
	logic [1:0] fifo_cnt_r;
	logic push_valid;
	logic push_ready;
	logic pop_valid;
	logic pop_ready;
	logic [17:0] push_data;

	assign fbuf_to_asm = fbuf_full_r && !asm_full_r;
	assign push_valid = asm_full_r;
	assign push_ready = fifo_cnt_r != FIFO_DEPTH;
	assign push_data = asm_half_r ? asm_r[18:35] : asm_r[0:17];
	assign pop_valid = fifo_cnt_r != 2'h0;
	assign pop_ready = sclk_rise && run_r && pins_s_r.attached;

	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			fbuf_r <= WORD_RST;
			fbuf_full_r <= 1'b0;
		end else if (wpulse_rise && owned_r) begin
			fbuf_r <= pins_s_r.fdata;
			fbuf_full_r <= 1'b1;
		end else if (fbuf_to_asm) begin
			fbuf_full_r <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			asm_r <= WORD_RST;
			asm_full_r <= 1'b0;
			asm_half_r <= 1'b0;
		end else if (fbuf_to_asm) begin
			asm_r <= fbuf_r;
			asm_full_r <= 1'b1;
			asm_half_r <= 1'b0;
		end else if (push_valid && push_ready) begin
			asm_half_r <= ~asm_half_r;
			asm_full_r <= ~asm_half_r;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			fifo_wp_r <= 1'b0;
			fifo_rp_r <= 1'b0;
			fifo_cnt_r <= 2'h0;
			wdata_o <= 18'h00000;
		end else begin
			if (push_valid && push_ready) begin
				fifo_mem_r[fifo_wp_r] <= push_data;
				fifo_wp_r <= ~fifo_wp_r;
			end
			if (pop_valid && pop_ready) begin
				wdata_o <= fifo_mem_r[fifo_rp_r];
				fifo_rp_r <= ~fifo_rp_r;
			end
			fifo_cnt_r <= fifo_cnt_r + 2'(push_valid && push_ready)
				- 2'(pop_valid && pop_ready);
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			write_echo_o <= 1'b0;
		end else begin
			write_echo_o <= run_r && pins_s_r.sclk;
		end
	end

	// ---------------------------------------------
	// outputs
	// ---------------------------------------------
	assign access_collision_o = collision_r;
	assign busy_o = busy_r;
	assign done_o = done_r;
	assign feeder_start_request_o = session_r;
	assign controller_word_pulse_o = cwp_r;
	assign first_control_word_pointer_o = xcmd_r[CWP_LO:CWP_HI];
	assign drv_ctl_o = ctl_r;
	assign cycle_strobe_o = strobe_r;
	assign ctl_data_oe_o = cyc_in_flight_r && ctl_r.ctod;
	assign run_o = run_r;
	assign wdata_oe_o = run_r && pins_s_r.attached;

	// ---------------------------------------------
	// assertions
	// ---------------------------------------------
	default clocking chk_clk @(posedge ref_clk_i); endclocking
	default disable iff (srst_i);

	sequence s_read_tail;
		##7 read_data_load ##5 cycle_end;
	endsequence

	a_overrun_flag: assert property (
		acc_req && acc_state_r != AC_IDLE |=> collision_r && $stable(pend_r))
		else $error("collision not flagged");
	a_addr_load_delay: assert property (
		acc_accept |-> ##4 addr_load) else $error("address load timing");
	a_strobe_settle: assert property (
		addr_load |-> ##11 !cycle_strobe_o ##1 cycle_strobe_o)
		else $error("strobe settle timing");
	a_write_end: assert property (
		acc_state_r == AC_WAIT_ACK && ack_rise && !acc_rd_r |=> !cycle_strobe_o)
		else $error("write cycle not ended");
	a_read_tail: assert property (
		acc_state_r == AC_WAIT_ACK && ack_rise && acc_rd_r |-> s_read_tail)
		else $error("read tail timing");
	a_parity_fault: assert property (
		read_data_load && !(^{pins_s_r.ddata, pins_s_r.par}) |-> ##6 parf_r)
		else $error("parity fault missed");
	a_start_request: assert property (
		xcmd_load |-> ##2 feeder_start_request_o) else $error("start request late");
	a_busy_ignore: assert property (
		xfer_cmd && busy_r |=> $stable(xcmd_r)) else $error("command taken while busy");
	a_session_drop: assert property (
		busy_fall && !pending_r |=> !feeder_start_request_o)
		else $error("start request not dropped");
	a_block_end: assert property (
		blk_end_rise && busy_r |=> done_o && !busy_o) else $error("block end missed");
	a_go_withheld: assert property (
		addr_load && blocked_fn |=> !drv_ctl_o.data[GO_BIT] && block_r)
		else $error("start bit not withheld");
endmodule

// file: dbw_pkg.sv
package dbw_pkg;
	localparam int CLK_NS = 25;
	localparam int ADDR_DLY_NS = 100;
	localparam int SETTLE_NS = 275;
	localparam int RD_DESKEW_NS = 175;
	localparam int PAR_WIN_NS = 125;
	localparam int ACK_TMO_NS = 1500;
	function automatic int ns2cyc(input int ns);
		return (ns + CLK_NS - 1) / CLK_NS;
	endfunction
	localparam int ADDR_DLY_CYC = ns2cyc(ADDR_DLY_NS);
	localparam int SETTLE_CYC = ns2cyc(SETTLE_NS);
	localparam int RD_DESKEW_CYC = ns2cyc(RD_DESKEW_NS);
	localparam int PAR_WIN_CYC = ns2cyc(PAR_WIN_NS);
	localparam int ACK_TMO_CYC = ns2cyc(ACK_TMO_NS);
	// host word fields, bit 0 is the most significant
	localparam int REG_SEL_LO = 0;
	localparam int REG_SEL_HI = 5;
	localparam int CTOD_BIT = 6;
	localparam int NORESP_BIT = 7;
	localparam int PARF_BIT = 8;
	localparam int STALE_BIT = 9;
	localparam int BLOCK_BIT = 10;
	localparam int DRSEL_LO = 15;
	localparam int DRSEL_HI = 17;
	localparam int CWP_LO = 18;
	localparam int CWP_HI = 29;
	localparam int PAR_LINE_BIT = 19;
	localparam int DATA_LO = 20;
	localparam int DATA_HI = 35;
	localparam int FN_LO = 30;
	localparam int FN_HI = 35;
	// drive register data fields
	localparam int GO_BIT = 0;
	localparam int FN_XFER_BIT = 5;
	localparam logic [5:0] CTL_REG_SEL = 6'h00;
	localparam logic [5:0] XFER_CMD_ADDR = 6'h20;
	localparam logic [5:0] FN_WRITE_GO = 6'h31;
	localparam logic [0:35] WORD_RST = 36'h0;
	localparam logic [1:0] FIFO_DEPTH = 2'h2;
	typedef enum logic [2:0] {
		AC_IDLE, AC_ADDR_DLY, AC_SETTLE, AC_WAIT_ACK, AC_RD_DESKEW, AC_PARITY
	} dbw_acc_state_t;
	typedef struct packed {
		logic busy;
		logic wpulse;
		logic ack;
		logic attached;
		logic sclk;
		logic blk_end;
		logic par;
		logic [15:0] ddata;
		logic [0:35] fdata;
	} dbw_pins_t;
	typedef struct packed {
		logic [5:0] sel;
		logic ctod;
		logic [2:0] drv;
		logic [15:0] data;
	} dbw_ctl_t;
endpackage

// file: dbw_drive_model.sv
module dbw_drive_model import dbw_pkg::*; (
	input wire logic ref_clk_i,
	input wire logic present_i,
	input wire logic bad_par_i,
	input wire dbw_ctl_t drv_ctl_i,
	input wire logic cycle_strobe_i,
	input wire logic run_i,
	input wire logic [17:0] wdata_i,
	output logic ack_o,
	output logic [15:0] ddata_o,
	output logic par_o,
	output logic attached_o,
	output logic sclk_o,
	output logic blk_end_o
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [15:0] regs [0:63];
	logic [17:0] halves [$];
	int dly = 0;
	int ph = 0;
	initial begin
		{ack_o, ddata_o, par_o, attached_o, sclk_o, blk_end_o} = 21'h0;
	end
	// ----
	// control bus side
	// ----
	always @(posedge ref_clk_i) begin
		if (cycle_strobe_i && present_i && !ack_o) begin
			dly <= dly + 1;
			if (dly == 3) begin
				ack_o <= 1'b1;
				if (drv_ctl_i.ctod) begin
					regs[drv_ctl_i.sel] <= drv_ctl_i.data;
				end else begin
					ddata_o <= regs[drv_ctl_i.sel];
					par_o <= ~^regs[drv_ctl_i.sel] ^ bad_par_i;
				end
			end
		end else if (!cycle_strobe_i) begin
			dly <= 0;
			ack_o <= 1'b0;
			// released lines never hold the last value
			ddata_o <= ~ddata_o;
			par_o <= ~par_o;
		end
	end
	// ----
	// sync data side
	// ----
	always @(posedge ref_clk_i) begin
		attached_o <= run_i;
		blk_end_o <= 1'b0;
		if (run_i && attached_o && halves.size() < 4) begin
			ph <= (ph + 1) % 8;
			sclk_o <= (ph < 4);
			if (sclk_o && ph == 4) begin
				halves.push_back(wdata_i);
				if (halves.size() == 4)
					blk_end_o <= 1'b1;
			end
		end else begin
			ph <= 0;
			sclk_o <= 1'b0;
		end
	end
endmodule

// file: testbench.sv
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin fails++; \
	$display("MISMATCH t=%0t got %h exp %h", $time, a, b); end end
module testbench import dbw_pkg::*;;
	timeunit 1ns;
	timeprecision 100ps;
	typedef struct packed {logic [5:0] sel; logic [2:0] drv; logic [15:0] data;} dbw_row_t;
	logic clk = 1'b0, srst = 1'b1, io_out = 1'b0, io_in = 1'b0;
	logic [5:0] io_addr = 6'h00;
	logic [0:35] io_data = 36'h0, ch_word = 36'h0, rdata;
	logic ch_busy = 1'b0, ch_wp = 1'b0, present = 1'b1, bad_par = 1'b0;
	logic coll, busy, done, start, cwpls, strobe, oe, run, echo, woe, echo_q, run_seen = 1'b0;
	logic ack, par, att, sclk, blk_end;
	logic [15:0] ddata;
	logic [11:0] cwp;
	logic [17:0] wdata;
	dbw_ctl_t ctl;
	dbw_pins_t pins;
	int fails = 0, samples_checked = 0, cyc = 0, echo_n = 0, n;
	logic [0:35] words [2] = '{36'h1_2345_6789, 36'hF_EDCB_A987};
	dbw_row_t rows [3] = '{'{6'h03, 3'h0, 16'hA5C3}, '{6'h1F, 3'h7, 16'h0001},
		'{6'h12, 3'h5, 16'hFFFF}};
	assign pins = '{busy: ch_busy, wpulse: ch_wp, ack: ack, attached: att, sclk: sclk,
		blk_end: blk_end, par: par, ddata: ddata, fdata: ch_word};
	dbw_bridge i_dbw_bridge (.ref_clk_i(clk), .srst_i(srst), .io_out_i(io_out),
		.io_in_i(io_in), .io_addr_i(io_addr), .io_data_i(io_data), .io_rdata_o(rdata),
		.access_collision_o(coll), .busy_o(busy), .done_o(done),
		.feeder_start_request_o(start), .controller_word_pulse_o(cwpls),
		.first_control_word_pointer_o(cwp), .pins_i(pins), .drv_ctl_o(ctl),
		.cycle_strobe_o(strobe), .ctl_data_oe_o(oe), .run_o(run), .write_echo_o(echo),
		.wdata_o(wdata), .wdata_oe_o(woe));
	dbw_drive_model i_dbw_drive_model (.ref_clk_i(clk), .present_i(present),
		.bad_par_i(bad_par), .drv_ctl_i(ctl), .cycle_strobe_i(strobe), .run_i(run),
		.wdata_i(wdata), .ack_o(ack), .ddata_o(ddata), .par_o(par), .attached_o(att),
		.sclk_o(sclk), .blk_end_o(blk_end));
	initial begin
		forever #12.5 clk = ~clk;
	end
	always @(negedge clk) begin
		if (run === 1'b1 && woe === 1'b1)
			run_seen <= 1'b1;
		echo_q <= echo;
		if (echo === 1'b1 && echo_q === 1'b0)
			echo_n <= echo_n + 1;
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			fails++;
			print_verdict();
		end
	end
	// ----
	// host tasks
	// ----
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	function automatic logic [0:35] mkw(logic ctod, dbw_row_t r);
		mkw = 36'h0;
		mkw[0:5] = r.sel;
		mkw[6] = ctod;
		mkw[15:17] = r.drv;
		mkw[20:35] = r.data;
	endfunction
	task automatic host(logic out, logic [5:0] a, logic [0:35] w);
		@(posedge clk);
		io_out <= out;
		io_in <= !out;
		io_addr <= a;
		io_data <= w;
		@(posedge clk);
		io_out <= 1'b0;
		io_in <= 1'b0;
	endtask
	task automatic fin(logic ctod, dbw_row_t r, int lead = 0);
		n = 0;
		while (strobe !== 1'b1 && n < 40) begin @(negedge clk); n++; end
		`CHK(n + lead, ADDR_DLY_CYC + SETTLE_CYC + 1)
		`CHK({ctl.sel, ctl.ctod, ctl.drv}, {r.sel, ctod, r.drv})
		if (ctod) `CHK({ctl.data, oe}, {r.data, 1'b1})
		n = 0;
		while (strobe !== 1'b0 && n < 200) begin @(negedge clk); n++; end
		`CHK(strobe, 1'b0)
		repeat (2) @(negedge clk);
	endtask
	task automatic acc(logic ctod, dbw_row_t r);
		host(1'b1, 6'h00, mkw(ctod, r));
		fin(ctod, r);
	endtask
	task automatic rdbk();
		host(1'b0, 6'h00, 36'h0);
		repeat (2) @(negedge clk);
	endtask
	task automatic wpls();
		n = 0;
		while (cwpls !== 1'b1 && n < 60) begin @(negedge clk); n++; end
		`CHK(cwpls, 1'b1)
	endtask
	// ----
	// main sequence
	// ----
	initial begin
		repeat (5) @(posedge clk);
		srst <= 1'b0;
		repeat (2) @(negedge clk);
		`CHK({rdata, coll, busy, done, start, strobe, run}, 42'h0)
		foreach (rows[i]) begin
			acc(1'b1, rows[i]);
			acc(1'b0, rows[i]);
			rdbk();
			`CHK({rdata[20:35], rdata[7:10]}, {rows[i].data, 4'h0})
		end
		// second access while the first runs
		host(1'b1, 6'h00, mkw(1'b0, rows[0]));
		host(1'b1, 6'h00, mkw(1'b1, rows[2]));
		@(negedge clk);
		`CHK(coll, 1'b1)
		fin(1'b0, rows[0], 3);
		repeat (30) @(negedge clk);
		`CHK(strobe, 1'b0)
		// early input instruction
		host(1'b1, 6'h00, mkw(1'b0, rows[0]));
		host(1'b0, 6'h00, 36'h0);
		fin(1'b0, rows[0], 2);
		rdbk();
		`CHK(rdata[9], 1'b1)
		bad_par <= 1'b1;
		acc(1'b0, rows[1]);
		rdbk();
		`CHK(rdata[8], 1'b1)
		bad_par <= 1'b0;
		present <= 1'b0;
		acc(1'b1, rows[0]);
		rdbk();
		`CHK(rdata[7], 1'b1)
		present <= 1'b1;
		host(1'b1, 6'h00, mkw(1'b1, '{6'h00, 3'h2, 16'h0031}));
		fin(1'b1, '{6'h00, 3'h2, 16'h0030});
		rdbk();
		`CHK(rdata[10], 1'b1)
		acc(1'b0, '{6'h00, 3'h2, 16'h0030});
		rdbk();
		`CHK({rdata[20:35], rdata[10]}, {16'h0030, 1'b0})
		// write transfer
		host(1'b1, XFER_CMD_ADDR, {15'h0, 3'h2, 12'h123, FN_WRITE_GO});
		repeat (3) @(negedge clk);
		`CHK({busy, start}, 2'b11)
		host(1'b1, XFER_CMD_ADDR, {15'h0, 3'h5, 12'h777, FN_WRITE_GO});
		@(posedge clk) ch_busy <= 1'b1;
		wpls();
		`CHK(cwp, 12'h123)
		for (int k = 0; k < 2; k++) begin
			repeat (8) @(negedge clk);
			@(posedge clk);
			ch_word <= words[k];
			ch_wp <= 1'b1;
			@(posedge clk) ch_wp <= 1'b0;
			wpls();
		end
		@(posedge clk) ch_busy <= 1'b0;
		repeat (6) @(negedge clk);
		`CHK(start, 1'b0)
		n = 0;
		while (done !== 1'b1 && n < 400) begin @(negedge clk); n++; end
		`CHK({done, busy}, 2'b10)
		`CHK(run_seen, 1'b1)
		`CHK(echo_n, 4)
		`CHK(i_dbw_drive_model.regs[0], 16'h0031)
		`CHK(i_dbw_drive_model.halves.size(), 4)
		for (int k = 0; k < 4; k++)
			`CHK(i_dbw_drive_model.halves[k], words[k / 2][18 * (k % 2) +: 18])
		print_verdict();
	end
endmodule
